// ---- bench/clf_host.sv ----
// host model sending periodic valid messages
`timescale 1ns/10ps
`default_nettype none
module clf_host
  #(parameter int GAP = 10)
(
  input wire logic ref_clk,
  input wire logic run,
  output var logic msg_valid
);
  int cnt = 0;
  // one pulse per gap; stopping run models a lost link
  always @(negedge ref_clk) begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    msg_valid <= run && cnt == 0;
  end
endmodule : clf_host
`default_nettype wire

// ---- bench/clf_sva.sv ----
// assertions for the comm loss failsafe block
`timescale 1ns/10ps
`default_nettype none
module clf_sva
  import clf_pkg::*;
(
  // watched ports
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic msg_valid,
  input wire logic [CLF_TMO_W-1:0] fs_period,
  input wire clf_fs_cfg_s fs_cfg,
  input wire logic [CLF_N_DOUT-1:0] dout_norm,
  input wire logic [CLF_N_PWM-1:0] pwm_en,
  input wire logic uid_we,
  input wire logic [7:0] uid_wdata,
  input wire clf_recov_cmd_s recov_cmd,
  input wire logic [CLF_N_DOUT-1:0] dout,
  input wire logic [CLF_N_PWM-1:0] pwm_out,
  input wire logic step_emerg,
  input wire logic failsafe,
  input wire logic [7:0] user_id,
  input wire logic recovery,
  input wire logic cfg_erase,
  input wire logic fw_reload
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // silent edges since the last host message or reset
  logic [CLF_TMO_W-1:0] sil_q;
  always_ff @(posedge ref_clk) begin
    if (reset || msg_valid) begin
      sil_q <= '0;
    end else begin
      sil_q <= sil_q + 1'b1;
    end
  end
  a_fs_delay: assert property ($rose(failsafe)
    |-> sil_q == fs_period + 32'h1)
    else $error("failsafe raised at wrong silence length");
  a_fs_clear: assert property (msg_valid |=> !failsafe)
    else $error("failsafe kept after host message");
  a_dout_fs: assert property (failsafe |=> dout == $past(fs_cfg.level))
    else $error("dout not at failsafe level");
  a_dout_norm: assert property (!failsafe |=> dout == $past(dout_norm))
    else $error("dout not at normal value");
  a_step_emerg: assert property (failsafe |=> step_emerg)
    else $error("step generator not in emergency");
  a_pwm_off: assert property (!pwm_en[2] [*3] |-> !pwm_out[2])
    else $error("disabled pwm channel active");
  a_uid_write: assert property (uid_we |=> user_id == $past(uid_wdata))
    else $error("user id not written");
  a_uid_hold: assert property (!uid_we |=> $stable(user_id))
    else $error("user id changed without write");
  a_cmd_gate: assert property (!recovery && !$past(recovery)
    |-> !cfg_erase && !fw_reload)
    else $error("recovery command outside recovery");
  a_erase_cmd: assert property (recov_cmd.erase
    |=> cfg_erase == recovery)
    else $error("erase command mishandled");
  a_reload_cmd: assert property (recov_cmd.reload
    |=> fw_reload == recovery)
    else $error("reload command mishandled");
  // main scenarios reached
  c_fs: cover property ($rose(failsafe));
  c_recov: cover property ($rose(recovery));
  c_erase: cover property ($rose(cfg_erase));
endmodule : clf_sva
bind clf_top clf_sva chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .msg_valid(msg_valid),
  .fs_period(fs_period),
  .fs_cfg(fs_cfg),
  .dout_norm(dout_norm),
  .pwm_en(pwm_en),
  .uid_we(uid_we),
  .uid_wdata(uid_wdata),
  .recov_cmd(recov_cmd),
  .dout(dout),
  .pwm_out(pwm_out),
  .step_emerg(step_emerg),
  .failsafe(failsafe),
  .user_id(user_id),
  .recovery(recovery),
  .cfg_erase(cfg_erase),
  .fw_reload(fw_reload)
);
`default_nettype wire

// ---- bench/test_clf_top.sv ----
// self-checking bench for the comm loss failsafe block
`timescale 1ns/10ps
`default_nettype none
module test_clf_top
  import clf_pkg::*;
;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic host_run = 1'h0;
  logic msg_valid, uid_we = 1'h0, reset_sw = 1'h0, usb_attach = 1'h0;
  logic step_emerg, failsafe, recovery, led_green, cfg_erase, fw_reload;
  logic [CLF_TMO_W-1:0] fs_period = 32'h14;
  clf_fs_cfg_s fs_cfg = {8'hA5, 7'h32, 7'h32, 7'h64, 7'h1E};
  logic [CLF_N_DOUT-1:0] dout_norm = 8'h3C, dout;
  logic [CLF_PWM_W-1:0] pwm_period = 32'hA;
  // failsafe duties differ from normal ones on channels 0 and 3
  logic [CLF_N_PWM-1:0][CLF_PWM_W-1:0] pwm_duty = {32'h2, 32'h5, 32'hA, 32'h0};
  logic [CLF_N_PWM-1:0] pwm_en = 4'hB, pwm_out;
  logic [7:0] uid_wdata = 8'h00, user_id;
  clf_recov_cmd_s recov_cmd = 2'h0;
  int fails = 0, n_checks = 0, cyc = 0;
  clf_top DUT (
    .ref_clk(ref_clk),
    .reset(reset),
    .msg_valid(msg_valid),
    .fs_period(fs_period),
    .fs_cfg(fs_cfg),
    .dout_norm(dout_norm),
    .pwm_period(pwm_period),
    .pwm_duty(pwm_duty),
    .pwm_en(pwm_en),
    .uid_we(uid_we),
    .uid_wdata(uid_wdata),
    .reset_sw(reset_sw),
    .usb_attach(usb_attach),
    .recov_cmd(recov_cmd),
    .dout(dout),
    .pwm_out(pwm_out),
    .step_emerg(step_emerg),
    .failsafe(failsafe),
    .user_id(user_id),
    .recovery(recovery),
    .led_green(led_green),
    .cfg_erase(cfg_erase),
    .fw_reload(fw_reload)
  );
  clf_host host (.ref_clk, .run(host_run), .msg_valid);
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  // 40 cycles span two whole periods, so the count is phase free
  task automatic pwm_chk(input logic fs);
    logic [31:0] n;
    int e;
    for (int i = 0; i < CLF_N_PWM; i++) begin
      n = 0;
      repeat (40) begin
        @(negedge ref_clk);
        n += pwm_out[i];
      end
      e = fs ? fs_cfg.pct[i] : pwm_duty[i] * 100 / pwm_period;
      e = pwm_en[i] ? 40 * e / 100 : 0;
      chk("pwm_out", e, n);
    end
  endtask : pwm_chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n
  task automatic uid_wr(input logic [7:0] v);
    @(negedge ref_clk);
    uid_we = 1'h1;
    uid_wdata = v;
    wait_n(1);
    uid_we = 1'h0;
    wait_n(1);
    chk("user_id", v, user_id);
  endtask : uid_wr
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // hang guard, run needs about 490 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    wait_n(16);
    reset = 1'h0;
    usb_attach = 1'h1;
    host_run = 1'h1;
    wait_n(60);
    chk("recovery", 0, recovery);
    chk("failsafe", 0, failsafe);
    chk("dout", dout_norm, dout);
    chk("step_emerg", 0, step_emerg);
    chk("led_green", 1, led_green);
    pwm_chk(1'h0);
    host_run = 1'h0;
    wait_n(40);
    chk("failsafe", 1, failsafe);
    chk("dout", fs_cfg.level, dout);
    chk("step_emerg", 1, step_emerg);
    pwm_chk(1'h1);
    host_run = 1'h1;
    wait_n(12);
    chk("failsafe", 0, failsafe);
    chk("dout", dout_norm, dout);
    chk("step_emerg", 0, step_emerg);
    uid_wr(8'hFF);
    uid_wr(8'h00);
    // switch held while connected must not enter recovery
    recov_cmd = 2'h3;
    reset_sw = 1'h1;
    wait_n(10);
    chk("recovery", 0, recovery);
    chk("cfg_erase", 0, cfg_erase);
    chk("fw_reload", 0, fw_reload);
    recov_cmd = 2'h0;
    usb_attach = 1'h0;
    wait_n(10);
    usb_attach = 1'h1;
    wait_n(10);
    chk("recovery", 1, recovery);
    chk("led_green", 0, led_green);
    reset_sw = 1'h0;
    recov_cmd = 2'h2;
    wait_n(1);
    chk("cfg_erase", 1, cfg_erase);
    recov_cmd = 2'h1;
    wait_n(1);
    chk("fw_reload", 1, fw_reload);
    recov_cmd = 2'h0;
    summarize();
  end
endmodule : test_clf_top
`default_nettype wire

// ---- core/clf_pkg.sv ----
// constants and types for the comm loss failsafe block
// Function
// R1: after host silence longer than the timeout, outputs go failsafe.
// R2: in failsafe each digital output takes its configured off or on level.
// R3: in failsafe each pwm output runs at its configured fixed duty percent.
// R4: in failsafe the step pulse generator enters emergency mode, no setting.
// R5: each pwm channel has its own enable, independent of the other channels.
// R6: each pwm duty spans 0% (never active) to 100% (always active).
// R7: an 8-bit host-writable user identifier holds any value from 0 to 255.
// R8: the reset switch held at usb connect starts the device in recovery mode.
// R9: in recovery mode the green status indicator flashes rapidly.
// R10: recovery mode accepts host commands to erase config or reload firmware.
// R11: all pwm channels share one period, each with its own duty.
// R12: pwm period and duty count cycles of a 25 MHz module clock.
// R13: the timeout counter restarts on each host message, trips at the period.
package clf_pkg;
  // ----------------------------------------
  // sizes and clocks
  // ----------------------------------------
  localparam int CLF_N_DOUT = 8;
  localparam int CLF_N_PWM = 4;
  localparam int CLF_PWM_W = 32;
  localparam int CLF_TMO_W = 32;
  localparam int CLF_SYS_HZ = 50000000;
  localparam int CLF_PWM_HZ = 25000000;
  localparam int CLF_PWM_DIV = CLF_SYS_HZ / CLF_PWM_HZ;
  // rapid flash half period, 62 ms
  localparam int CLF_FLASH_MS = 62;
  localparam int CLF_FLASH_CYC = CLF_FLASH_MS * (CLF_SYS_HZ / 1000);
  localparam logic [CLF_TMO_W-1:0] CLF_TMO_RST = 32'h02FA_F080;
  localparam logic [6:0] CLF_PCT_MAX = 7'h64;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CLF_ST_BOOT = 3'b001,
    CLF_ST_NORM = 3'b010,
    CLF_ST_RECOV = 3'b100
  } clf_mode_e;

  typedef struct packed {
    logic erase;
    logic reload;
  } clf_recov_cmd_s;

  typedef struct packed {
    logic [CLF_N_DOUT-1:0] level;
    logic [CLF_N_PWM-1:0][6:0] pct;
  } clf_fs_cfg_s;
endpackage : clf_pkg

// ---- core/clf_top.sv ----
// comm loss failsafe supervisor with pwm, user id and recovery entry
`timescale 1ns/10ps
`default_nettype none
module clf_top
  import clf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host message side
  input wire logic msg_valid,
  input wire logic [CLF_TMO_W-1:0] fs_period,
  input wire clf_fs_cfg_s fs_cfg,
  // normal output values
  input wire logic [CLF_N_DOUT-1:0] dout_norm,
  input wire logic [CLF_PWM_W-1:0] pwm_period,
  input wire logic [CLF_N_PWM-1:0][CLF_PWM_W-1:0] pwm_duty,
  input wire logic [CLF_N_PWM-1:0] pwm_en,
  // user id write
  input wire logic uid_we,
  input wire logic [7:0] uid_wdata,
  // recovery entry and commands
  input wire logic reset_sw,
  input wire logic usb_attach,
  input wire clf_recov_cmd_s recov_cmd,
  // outputs
  output logic [CLF_N_DOUT-1:0] dout,
  output logic [CLF_N_PWM-1:0] pwm_out,
  output logic step_emerg,
  output logic failsafe,
  output logic [7:0] user_id,
  output logic recovery,
  output logic led_green,
  output logic cfg_erase,
  output logic fw_reload
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // percent of period, computed wide to avoid overflow
  function automatic logic [CLF_PWM_W-1:0] pct_to_cyc(
    input logic [CLF_PWM_W-1:0] per, input logic [6:0] pct);
    logic [CLF_PWM_W+6:0] prod;
    prod = per * pct;
    return CLF_PWM_W'(prod / CLF_PCT_MAX);
  endfunction : pct_to_cyc

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sw_sync_q;
  logic [2:0] usb_sync_q;
  logic sw_lvl_q;
  logic usb_lvl_q;
  logic usb_prev_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sw_sync_q <= 3'h0;
      usb_sync_q <= 3'h0;
      sw_lvl_q <= 1'b0;
      usb_lvl_q <= 1'b0;
      usb_prev_q <= 1'b0;
    end else begin
      sw_sync_q <= {sw_sync_q[1:0], reset_sw};
      usb_sync_q <= {usb_sync_q[1:0], usb_attach};
      if (sw_sync_q[1] == sw_sync_q[2]) begin
        sw_lvl_q <= sw_sync_q[2];
      end
      if (usb_sync_q[1] == usb_sync_q[2]) begin
        usb_lvl_q <= usb_sync_q[2];
      end
      usb_prev_q <= usb_lvl_q;
    end
  end

  // ----------------------------------------
  // boot mode
  // ----------------------------------------
  clf_mode_e mode_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= CLF_ST_BOOT;
    end else begin
      case (mode_q)
        CLF_ST_BOOT: begin
          // R8: switch held at connect
          if (usb_lvl_q && !usb_prev_q) begin
            mode_q <= sw_lvl_q ? CLF_ST_RECOV : CLF_ST_NORM;
          end
        end
        // unplug returns to boot so next connect decides again
        CLF_ST_NORM, CLF_ST_RECOV: begin
          if (!usb_lvl_q) begin
            mode_q <= CLF_ST_BOOT;
          end
        end
        default: mode_q <= CLF_ST_BOOT;
      endcase
    end
  end
  logic in_recov;
  assign in_recov = (mode_q == CLF_ST_RECOV);

  // ----------------------------------------
  // recovery outputs
  // ----------------------------------------
  logic [25:0] flash_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      recovery <= 1'b0;
      led_green <= 1'b0;
      flash_cnt_q <= 26'h0;
      cfg_erase <= 1'b0;
      fw_reload <= 1'b0;
    end else begin
      recovery <= in_recov;
      // R9: rapid green flash
      if (!in_recov) begin
        flash_cnt_q <= 26'h0;
        led_green <= (mode_q == CLF_ST_NORM);
      end else if (flash_cnt_q == 26'(CLF_FLASH_CYC - 1)) begin
        flash_cnt_q <= 26'h0;
        led_green <= !led_green;
      end else begin
        flash_cnt_q <= flash_cnt_q + 26'h1;
      end
      // R10: commands honoured only in recovery
      cfg_erase <= in_recov && recov_cmd.erase;
      fw_reload <= in_recov && recov_cmd.reload;
    end
  end

  // ----------------------------------------
  // user id
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      user_id <= 8'h00;
    end else if (uid_we) begin
      // R7: any 8-bit value
      user_id <= uid_wdata;
    end
  end

  // ----------------------------------------
  // failsafe timeout
  // ----------------------------------------
  logic [CLF_TMO_W-1:0] tmo_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tmo_cnt_q <= '0;
      failsafe <= 1'b0;
    end else if (msg_valid) begin
      // R13: restart on message
      tmo_cnt_q <= '0;
      failsafe <= 1'b0;
    end else if (tmo_cnt_q >= fs_period) begin
      // R1: silence longer than period
      failsafe <= 1'b1;
    end else begin
      tmo_cnt_q <= tmo_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // digital outputs and step generator
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dout <= '0;
      step_emerg <= 1'b0;
    end else begin
      // R2: preset level per output
      dout <= failsafe ? fs_cfg.level : dout_norm;
      // R4: emergency on failsafe
      step_emerg <= failsafe;
    end
  end

  // ----------------------------------------
  // pwm module on 25 MHz enable
  // ----------------------------------------
  logic pwm_tick_q;
  logic [CLF_PWM_W-1:0] pwm_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwm_tick_q <= 1'b0;
    end else begin
      // R12: 25 MHz count enable
      pwm_tick_q <= !pwm_tick_q;
    end
  end

  // R11: one shared period counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwm_cnt_q <= '0;
    end else if (pwm_tick_q) begin
      if (pwm_cnt_q + 1'b1 >= pwm_period) begin
        pwm_cnt_q <= '0;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwm_out <= '0;
    end else begin
      for (int i = 0; i < CLF_N_PWM; i++) begin
        // R3: fixed percent in failsafe; R6: duty>=period is 100%
        if (!pwm_en[i]) begin
          // R5: per channel enable
          pwm_out[i] <= 1'b0;
        end else if (failsafe) begin
          pwm_out[i] <= pwm_cnt_q <
            pct_to_cyc(pwm_period, fs_cfg.pct[i]);
        end else begin
          pwm_out[i] <= pwm_cnt_q < pwm_duty[i];
        end
      end
    end
  end
endmodule : clf_top
`default_nettype wire
